// ===== verilog/mpba_top.sv
`timescale 1ns/100ps
`default_nettype none
module mpba_top
	import mpba_pkg::*;
#(
	parameter logic [mpba_pkg::MIN_W-1:0] MINUTE_CYCLES = mpba_pkg::MIN_W'(mpba_pkg::MINUTE_CYC),
	parameter logic [mpba_pkg::SLOW_W-1:0] SLOW_HALF = mpba_pkg::SLOW_W'(mpba_pkg::SLOW_HALF_CYC),
	parameter logic [mpba_pkg::FAST_W-1:0] FAST_HALF = mpba_pkg::FAST_W'(mpba_pkg::FAST_HALF_CYC)
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [mpba_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic shutdown_pin_n_i,
	input wire logic alert_in_i,
	input wire logic res_valid_i,
	input wire logic res_temp_i,
	input wire logic [2:0] res_chan_i,
	input wire logic [mpba_pkg::RES_W-1:0] res_data_i,
	output logic [mpba_pkg::NCH-1:0] balance_drive_o,
	output logic alert_o,
	output logic pd_full_o,
	output logic pd_soft_o
);
	import mpba_pkg::*;

	logic pin_s1_q, pin_s2_q, pin_s3_q;
	logic ain_s1_q, ain_s2_q;
	logic ack_q;
	logic [31:0] dat_q;
	logic [7:0] rdata;
	logic [7:0] ctrl_hi_q, ctrl_lo_q, ov_q, uv_q, ot_q, ut_q, alcfg_q, shutdown_delay_timer_q;
	mpba_pstate_t state_q;
	logic [4:0] dly_cnt_q;
	logic dly_hw_q;
	logic pd_full_q, pd_soft_q, alert_q;
	logic sq_slow_q, sq_fast_q;
	logic min_tick, slow_tick, fast_tick;
	logic [7:0] cbt_q [NCH];
	logic [4:0] bcnt_q [NCH];
	logic bal_q [NCH];
	logic vflt_q [NCH];
	logic tflt_q [NCH];
	logic [NCH-1:0] vflt, tflt, vinc, tinc, bal_vec;
	logic [5:0] idx;
	logic [7:0] wdat;
	logic wr_commit, cfg_wr, wr_ctrl_hi, running;
	logic pin_fall, pin_rise, hw_req, sw_req, sw_wake, pd_req;
	logic dly_done, pd_enter, enter_full, fault_any;
	logic [4:0] pdt_min;
	logic [1:0] am_mode, am_rate, vex, tex;
	logic [RES_W-THR_LSB-1:0] res_hi;

	// Pin synchronisers; stage one feeds only stage two
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_s1_q <= 1'b1;
			pin_s2_q <= 1'b1;
			pin_s3_q <= 1'b1;
			ain_s1_q <= 1'b0;
			ain_s2_q <= 1'b0;
		end else if (ce_i) begin
			pin_s1_q <= shutdown_pin_n_i;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			ain_s1_q <= alert_in_i;
			ain_s2_q <= ain_s1_q;
		end
	end

	assign pin_fall = pin_s3_q & ~pin_s2_q;
	assign pin_rise = ~pin_s3_q & pin_s2_q;

	// Wishbone slave: ack one cycle after strobe, write lands on the ack edge
	assign idx = wb_adr_i[ADR_W-1:2];
	assign wdat = wb_dat_i[7:0];
	assign wr_commit = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & wb_sel_i[0];
	assign running = (state_q == PS_RUN) || (state_q == PS_DELAY);
	assign cfg_wr = wr_commit & running;
	assign wr_ctrl_hi = wr_commit && (idx == IDX_CTRL_HI) && (state_q != PS_FULL);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else if (ce_i) begin
			ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
			if (wb_cyc_i & wb_stb_i & ~ack_q) begin
				dat_q <= {24'h00_0000, rdata};
			end
		end
	end

	always_comb begin
		rdata = RST_BYTE;
		case (idx)
			IDX_CTRL_HI: rdata = ctrl_hi_q;
			IDX_CTRL_LO: rdata = ctrl_lo_q;
			IDX_OV: rdata = ov_q;
			IDX_UV: rdata = uv_q;
			IDX_OT: rdata = ot_q;
			IDX_UT: rdata = ut_q;
			IDX_ALERT: rdata = alcfg_q;
			IDX_BAL: rdata = {2'h0, bal_vec};
			IDX_PDT: rdata = shutdown_delay_timer_q;
			IDX_STAT: rdata = {dly_cnt_q, state_q == PS_DELAY, pd_soft_q, pd_full_q};
			IDX_VFLT: rdata = {2'h0, vflt};
			IDX_TFLT: rdata = {2'h0, tflt};
			default: begin
				if (idx >= IDX_CBT0 && idx < IDX_CBT0 + 6'(NCH)) begin
					rdata = cbt_q[3'(idx - IDX_CBT0)];
				end
			end
		endcase
	end

	// Configuration registers; only the high control byte is writable in soft power-down
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_hi_q <= RST_BYTE;
			ctrl_lo_q <= RST_BYTE;
			ov_q <= RST_BYTE;
			uv_q <= RST_BYTE;
			ot_q <= RST_BYTE;
			ut_q <= RST_BYTE;
			alcfg_q <= RST_BYTE;
			shutdown_delay_timer_q <= RST_BYTE;
		end else if (ce_i) begin
			if (wr_ctrl_hi) begin
				ctrl_hi_q <= wdat;
			end
			if (cfg_wr) begin
				unique case (idx)
					IDX_CTRL_LO: ctrl_lo_q <= wdat;
					IDX_OV: ov_q <= wdat;
					IDX_UV: uv_q <= wdat;
					IDX_OT: ot_q <= wdat;
					IDX_UT: ut_q <= wdat;
					IDX_ALERT: alcfg_q <= wdat;
					IDX_PDT: shutdown_delay_timer_q <= wdat;
					default: ;
				endcase
			end
		end
	end

	// Power-down requests and shutdown delay
	assign pdt_min = shutdown_delay_timer_q[4:0];
	assign hw_req = pin_fall && (state_q != PS_FULL);
	assign sw_req = wr_ctrl_hi && wdat[CTRL_SWPD_BIT] && running;
	assign sw_wake = wr_ctrl_hi && !wdat[CTRL_SWPD_BIT] && (state_q == PS_SOFT);
	assign pd_req = hw_req | sw_req;
	assign dly_done = (state_q == PS_DELAY) && min_tick && (dly_cnt_q == 5'h01) && !pd_req;
	assign pd_enter = (pd_req && (pdt_min == 5'h00)) || dly_done;
	assign enter_full = dly_done ? dly_hw_q : hw_req;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= PS_RUN;
			dly_cnt_q <= 5'h00;
			dly_hw_q <= 1'b0;
		end else if (ce_i) begin
			unique case (state_q)
				PS_RUN, PS_DELAY, PS_SOFT: begin
					if (pd_req && pdt_min == 5'h00) begin
						state_q <= enter_full ? PS_FULL : PS_SOFT;
					end else if (pd_req) begin
						state_q <= PS_DELAY;
						dly_cnt_q <= pdt_min;
						dly_hw_q <= hw_req | ((state_q == PS_DELAY) & dly_hw_q);
					end else if (sw_wake) begin
						state_q <= PS_RUN;
					end else if (state_q == PS_DELAY && min_tick) begin
						if (dly_cnt_q == 5'h01) begin
							state_q <= enter_full ? PS_FULL : PS_SOFT;
						end
						dly_cnt_q <= dly_cnt_q - 5'h01;
					end
				end
				PS_FULL: begin
					if (pin_rise) begin
						state_q <= PS_RUN;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pd_full_q <= 1'b0;
			pd_soft_q <= 1'b0;
		end else if (ce_i) begin
			pd_full_q <= state_q == PS_FULL;
			pd_soft_q <= state_q == PS_SOFT;
		end
	end

	// Timebases: minute tick and the two square-wave half periods
	mpba_tick_gen #(.W(MIN_W), .DIV(MINUTE_CYCLES)) u_min (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.tick_o(min_tick)
	);
	mpba_tick_gen #(.W(SLOW_W), .DIV(SLOW_HALF)) u_slow (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.tick_o(slow_tick)
	);
	mpba_tick_gen #(.W(FAST_W), .DIV(FAST_HALF)) u_fast (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.tick_o(fast_tick)
	);

	// Alert configuration decode
	assign am_mode = alcfg_q[7:6];
	assign am_rate = alcfg_q[5:4];
	assign vex = alcfg_q[3:2];
	assign tex = alcfg_q[1:0];
	assign res_hi = res_data_i[RES_W-1:THR_LSB];

	// Per-channel balance drive, on-time timer and fault flags
	for (genvar i = 0; i < NCH; i++) begin : g_ch
		logic [4:0] lim;
		logic bal_wr, res_hit;
		assign lim = (cbt_q[i][4:0] > CBT_MAX) ? CBT_MAX : cbt_q[i][4:0];
		assign bal_wr = cfg_wr && (idx == IDX_BAL);
		assign res_hit = res_valid_i && running && (res_chan_i == 3'(i));
		assign vinc[i] = !((vex == EX_ONE || vex == EX_TWO) && i == VX_A) &&
			!(vex == EX_TWO && i == VX_B);
		assign tinc[i] = !((tex == EX_ONE || tex == EX_TWO) && i == TX_A) &&
			!(tex == EX_TWO && i == TX_B);
		assign vflt[i] = vflt_q[i];
		assign tflt[i] = tflt_q[i];
		assign bal_vec[i] = bal_q[i];
		assign balance_drive_o[i] = bal_q[i];

		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				cbt_q[i] <= RST_BYTE;
			end else if (ce_i && cfg_wr && idx == IDX_CBT0 + 6'(i)) begin
				cbt_q[i] <= wdat;
			end
		end

		// A zero on-time leaves the output on until cleared
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				bal_q[i] <= 1'b0;
				bcnt_q[i] <= 5'h00;
			end else if (ce_i) begin
				if (pd_enter) begin
					bal_q[i] <= 1'b0;
				end else if (bal_wr) begin
					bal_q[i] <= wdat[i];
					bcnt_q[i] <= lim;
				end else if (min_tick && bal_q[i] && bcnt_q[i] != 5'h00) begin
					if (bcnt_q[i] == 5'h01) begin
						bal_q[i] <= 1'b0;
					end
					bcnt_q[i] <= bcnt_q[i] - 5'h01;
				end
			end
		end

		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				vflt_q[i] <= 1'b0;
				tflt_q[i] <= 1'b0;
			end else if (ce_i) begin
				if (pd_enter) begin
					vflt_q[i] <= 1'b0;
					tflt_q[i] <= 1'b0;
				end else if (res_hit && !res_temp_i) begin
					vflt_q[i] <= (res_hi > ov_q) || (res_hi < uv_q);
				end else if (res_hit && res_temp_i) begin
					tflt_q[i] <= (res_hi > ot_q) || (res_hi < ut_q);
				end
			end
		end
	end

	assign fault_any = |(vflt & vinc) || |(tflt & tinc);

	// Square waves and alert output
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sq_slow_q <= 1'b0;
			sq_fast_q <= 1'b0;
		end else if (ce_i) begin
			if (slow_tick) begin
				sq_slow_q <= ~sq_slow_q;
			end
			if (fast_tick) begin
				sq_fast_q <= ~sq_fast_q;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			alert_q <= 1'b0;
		end else if (ce_i) begin
			if (state_q == PS_FULL) begin
				alert_q <= 1'b0;
			end else begin
				unique case (am_mode)
					AM_NONE: alert_q <= 1'b0;
					AM_STATIC: alert_q <= !fault_any;
					AM_SQUARE: begin
						if (am_rate == AR_SLOW) begin
							alert_q <= sq_slow_q & !fault_any;
						end else if (am_rate == AR_FAST) begin
							alert_q <= sq_fast_q & !fault_any;
						end else begin
							alert_q <= 1'b0;
						end
					end
					AM_PASS: alert_q <= ain_s2_q & !fault_any;
				endcase
			end
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
	assign alert_o = alert_q;
	assign pd_full_o = pd_full_q;
	assign pd_soft_o = pd_soft_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_req_zero;
		ce_i && pd_req && pdt_min == 5'h00;
	endsequence
	sequence s_req_delay;
		ce_i && pd_req && pdt_min != 5'h00;
	endsequence

	a_zero_delay_pd: assert property (s_req_zero |=>
		(state_q == PS_FULL || state_q == PS_SOFT) && bal_vec == 6'h00 ##1 (pd_full_o || pd_soft_o))
		else $error("zero delay request did not power down");
	a_delay_start: assert property (s_req_delay |=>
		state_q == PS_DELAY && dly_cnt_q == $past(pdt_min))
		else $error("delay request did not load the shutdown timer");
	a_pin_full_pd: assert property (ce_i && hw_req && pdt_min == 5'h00 |=>
		state_q == PS_FULL ##1 pd_full_o && !alert_o)
		else $error("pin fall did not give full power-down");
	a_soft_pd_bit: assert property (ce_i && sw_req && !hw_req && pdt_min == 5'h00 |=>
		state_q == PS_SOFT)
		else $error("software power-down bit ignored");
	a_pd_no_balance: assert property (state_q == PS_FULL || state_q == PS_SOFT |->
		bal_vec == 6'h00)
		else $error("balance drive on while powered down");
	a_reset_zero: assert property ($past(rst_i) |->
		shutdown_delay_timer_q == 8'h00 && bal_vec == 6'h00 && cbt_q[0] == 8'h00)
		else $error("registers not zero after reset");
	a_static_alert: assert property (ce_i && am_mode == AM_STATIC && state_q != PS_FULL |=>
		alert_o == !$past(fault_any))
		else $error("static alert does not follow fault");
	a_pass_alert: assert property (ce_i && am_mode == AM_PASS && state_q != PS_FULL |=>
		alert_o == ($past(ain_s2_q) && !$past(fault_any)))
		else $error("pass alert does not forward upstream");
	a_square_tog: assert property (ce_i && fast_tick |=> sq_fast_q != $past(sq_fast_q))
		else $error("fast square wave did not toggle");
	a_fault_flag: assert property (ce_i && !pd_enter && res_valid_i && running &&
		!res_temp_i && res_chan_i == 3'h0 && res_hi > ov_q |=> vflt[0])
		else $error("over-voltage result not flagged");
	a_bus_ack: assert property (wb_cyc_i && wb_stb_i && ce_i && !ack_q |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not one cycle after strobe");
endmodule
`default_nettype wire

// ===== include/mpba_pkg.sv
package mpba_pkg;
	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned MINUTE_S = 60;
	localparam longint unsigned MINUTE_CYC = 64'(MINUTE_S) * 64'(CLK_HZ);
	localparam int unsigned SLOW_HZ = 100;
	localparam int unsigned FAST_HZ = 1000;
	localparam int unsigned SLOW_HALF_CYC = CLK_HZ / (2 * SLOW_HZ);
	localparam int unsigned FAST_HALF_CYC = CLK_HZ / (2 * FAST_HZ);
	localparam int MIN_W = 34;
	localparam int SLOW_W = 20;
	localparam int FAST_W = 17;
	localparam int NCH = 6;
	localparam int RES_W = 12;
	localparam int THR_LSB = 4;
	localparam int ADR_W = 8;
	localparam logic [5:0] IDX_CTRL_HI = 6'h0D;
	localparam logic [5:0] IDX_CTRL_LO = 6'h0E;
	localparam logic [5:0] IDX_OV = 6'h0F;
	localparam logic [5:0] IDX_UV = 6'h10;
	localparam logic [5:0] IDX_OT = 6'h11;
	localparam logic [5:0] IDX_UT = 6'h12;
	localparam logic [5:0] IDX_ALERT = 6'h13;
	localparam logic [5:0] IDX_BAL = 6'h14;
	localparam logic [5:0] IDX_CBT0 = 6'h15;
	localparam logic [5:0] IDX_PDT = 6'h1B;
	localparam logic [5:0] IDX_STAT = 6'h1D;
	localparam logic [5:0] IDX_VFLT = 6'h1E;
	localparam logic [5:0] IDX_TFLT = 6'h1F;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam int CTRL_SWPD_BIT = 0;
	localparam logic [4:0] CBT_MAX = 5'h1E;
	localparam logic [1:0] AM_NONE = 2'h0;
	localparam logic [1:0] AM_STATIC = 2'h1;
	localparam logic [1:0] AM_SQUARE = 2'h2;
	localparam logic [1:0] AM_PASS = 2'h3;
	localparam logic [1:0] AR_SLOW = 2'h0;
	localparam logic [1:0] AR_FAST = 2'h1;
	localparam logic [1:0] EX_NONE = 2'h0;
	localparam logic [1:0] EX_ONE = 2'h1;
	localparam logic [1:0] EX_TWO = 2'h2;
	localparam int VX_A = 4;
	localparam int VX_B = 3;
	localparam int TX_A = 4;
	localparam int TX_B = 2;
	typedef enum logic [1:0] {PS_RUN, PS_DELAY, PS_SOFT, PS_FULL} mpba_pstate_t;
endpackage

// ===== verilog/mpba_tick_gen.sv
`timescale 1ns/100ps
`default_nettype none
module mpba_tick_gen #(
	parameter int W = 8,
	parameter logic [W-1:0] DIV = 8'hFF
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	output logic tick_o
);
	logic [W-1:0] cnt_q;
	logic tick_q;

	// One-cycle tick every DIV enabled cycles
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= '0;
			tick_q <= 1'b0;
		end else if (ce_i) begin
			if (cnt_q == DIV - W'(1)) begin
				cnt_q <= '0;
				tick_q <= 1'b1;
			end else begin
				cnt_q <= cnt_q + W'(1);
				tick_q <= 1'b0;
			end
		end
	end

	assign tick_o = tick_q;
endmodule
`default_nettype wire

// ===== testbench/mpba_chain_model.sv
`timescale 1ns/100ps
`default_nettype none
module mpba_chain_model #(
	parameter int HALF = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [1:0] mode_i,
	output logic alert_o
);
	int cnt_q;
	logic sq_q;
	always_ff @(posedge clk_i) begin
		if (rst_i || cnt_q == HALF - 1) begin
			cnt_q <= 0;
		end else begin
			cnt_q <= cnt_q + 1;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sq_q <= 1'b0;
		end else if (cnt_q == HALF - 1) begin
			sq_q <= ~sq_q;
		end
	end
	// Mode 0 originates static high, 1 a square wave, others a faulted neighbour
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			alert_o <= 1'b0;
		end else begin
			case (mode_i)
				2'h0: alert_o <= 1'b1;
				2'h1: alert_o <= sq_q;
				default: alert_o <= 1'b0;
			endcase
		end
	end
endmodule
`default_nettype wire

// ===== testbench/mpba_top_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) check(32'(g), 32'(e));
module mpba_top_bench;
	import mpba_pkg::*;
	localparam int MC = 50;
	localparam int SH = 20;
	localparam int FH = 6;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat_w = 32'h0;
	logic [31:0] dat_r;
	logic ack;
	logic pin_n = 1'b1;
	logic rv = 1'b0;
	logic rt = 1'b0;
	logic [2:0] rc = 3'h0;
	logic [11:0] rd_v = 12'h000;
	logic [5:0] bal;
	logic alert;
	logic pd_full;
	logic pd_soft;
	logic up_alert;
	logic [1:0] up_mode = 2'h0;
	int err_count = 0;
	int total_checks = 0;
	int seed = 32'h1f2f;
	int n;
	logic [31:0] q;
	logic [11:0] d;
	logic [7:0] p;
	logic [11:0] vals [3] = '{12'h500, 12'hF00, 12'h100};
	logic [7:0] xcfg [5] = '{8'h44, 8'h48, 8'h41, 8'h42, 8'h4C};
	logic xt [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
	logic [2:0] xch [5] = '{3'h4, 3'h3, 3'h4, 3'h2, 3'h4};
	logic xexp [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
	initial begin
		forever #2.5 clk_i = ~clk_i;
	end
	mpba_top #(.MINUTE_CYCLES(34'(MC)), .SLOW_HALF(20'(SH)), .FAST_HALF(17'(FH))) dut (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
		.wb_ack_o(ack), .shutdown_pin_n_i(pin_n), .alert_in_i(up_alert), .res_valid_i(rv),
		.res_temp_i(rt), .res_chan_i(rc), .res_data_i(rd_v), .balance_drive_o(bal),
		.alert_o(alert), .pd_full_o(pd_full), .pd_soft_o(pd_soft));
	mpba_chain_model #(.HALF(SH)) up (.clk_i(clk_i), .rst_i(rst_i), .mode_i(up_mode),
		.alert_o(up_alert));
	function automatic logic bad(input logic [11:0] v);
		return v[11:4] > 8'h80 || v[11:4] < 8'h20;
	endfunction
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic stop_test;
		$display("Counts: %0d checks, %0d mismatches", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] dv);
		int k;
		k = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		sel <= 4'h1;
		dat_w <= {24'h0, dv};
		@(posedge clk_i);
		while (ack !== 1'b1 && k < 50) begin
			@(posedge clk_i);
			k++;
		end
		if (k == 50) err_count++;
		q = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic res(input logic t, input logic [2:0] ch, input logic [11:0] v);
		rv <= 1'b1;
		rt <= t;
		rc <= ch;
		rd_v <= v;
		@(posedge clk_i);
		rv <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask
	// Watched output: 0 alert, 1 balance channel 0, 2 full power-down
	function automatic logic pick(input logic [1:0] sel);
		return (sel == 2'h0) ? alert : ((sel == 2'h1) ? bal[0] : pd_full);
	endfunction
	task automatic wait_for(input logic [1:0] sel, input logic v, input int lim);
		n = 0;
		while (pick(sel) !== v && n < lim) begin
			@(posedge clk_i);
			n++;
		end
	endtask
	task automatic half(input int exp);
		// Let a mode change reach the output so only true edges are timed
		@(posedge clk_i);
		wait_for(2'h0, 1'b0, 200);
		wait_for(2'h0, 1'b1, 200);
		wait_for(2'h0, 1'b0, 200);
		`CHK(n, exp)
	endtask
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		`CHK(bal, 6'h00)
		for (int i = 0; i < 6; i++) begin
			wb(1'b0, IDX_CBT0 + 6'(i), 8'h00);
			`CHK(q, 0)
		end
		wb(1'b0, IDX_PDT, 8'h00);
		`CHK(q, 0)
		wb(1'b1, 6'h1C, 8'h5A);
		wb(1'b0, 6'h1C, 8'h00);
		`CHK(q, 0)
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			p = 8'($random(seed));
			wb(1'b1, IDX_BAL, {2'b00, p[5:0]});
			`CHK(bal, p[5:0])
		end
		wb(1'b1, IDX_CBT0, 8'h02);
		wb(1'b1, IDX_BAL, 8'h3F);
		repeat (40) @(posedge clk_i);
		`CHK(bal, 6'h3F)
		wait_for(2'h1, 1'b0, 2 * MC + 10);
		`CHK(bal, 6'h3E)
		wb(1'b1, IDX_CBT0, 8'h00);
		$display("test balance done");
		wb(1'b1, IDX_OV, 8'h80);
		wb(1'b1, IDX_UV, 8'h20);
		wb(1'b1, IDX_OT, 8'h80);
		wb(1'b1, IDX_UT, 8'h20);
		wb(1'b0, IDX_OT, 8'h00);
		`CHK(q, 8'h80)
		wb(1'b1, IDX_ALERT, 8'h40);
		@(posedge clk_i);
		`CHK(alert, 1'b1)
		for (int i = 0; i < 8; i++) begin
			d = vals[($random(seed) & 32'h7FFF) % 3];
			p = 8'($random(seed));
			res(p[7], 3'(p[2:0] % 6), d);
			`CHK(alert, !bad(d))
			res(p[7], 3'(p[2:0] % 6), 12'h500);
		end
		for (int i = 0; i < 5; i++) begin
			wb(1'b1, IDX_ALERT, xcfg[i]);
			res(xt[i], xch[i], 12'hF00);
			`CHK(alert, xexp[i])
			res(xt[i], xch[i], 12'h500);
		end
		wb(1'b1, IDX_ALERT, 8'hC0);
		repeat (4) @(posedge clk_i);
		`CHK(alert, 1'b1)
		up_mode <= 2'h2;
		repeat (6) @(posedge clk_i);
		`CHK(alert, 1'b0)
		up_mode <= 2'h0;
		res(1'b0, 3'h1, 12'h100);
		`CHK(alert, 1'b0)
		res(1'b0, 3'h1, 12'h500);
		`CHK(alert, 1'b1)
		up_mode <= 2'h1;
		half(SH);
		up_mode <= 2'h0;
		wb(1'b1, IDX_ALERT, 8'h80);
		half(SH);
		wb(1'b1, IDX_ALERT, 8'h90);
		half(FH);
		wb(1'b1, IDX_ALERT, 8'hA0);
		repeat (30) @(posedge clk_i);
		`CHK(alert, 1'b0)
		wb(1'b1, IDX_ALERT, 8'h40);
		wb(1'b1, IDX_ALERT, 8'h00);
		@(posedge clk_i);
		`CHK(alert, 1'b0)
		$display("test alert done");
		wb(1'b1, IDX_BAL, 8'h3F);
		wb(1'b1, IDX_CTRL_HI, 8'h01);
		@(posedge clk_i);
		`CHK({pd_soft, bal}, 7'h40)
		wb(1'b1, IDX_CTRL_HI, 8'h00);
		@(posedge clk_i);
		`CHK(pd_soft, 1'b0)
		pin_n <= 1'b0;
		repeat (6) @(posedge clk_i);
		`CHK(pd_full, 1'b1)
		pin_n <= 1'b1;
		repeat (6) @(posedge clk_i);
		`CHK(pd_full, 1'b0)
		wb(1'b1, IDX_PDT, 8'h1F);
		wb(1'b0, IDX_PDT, 8'h00);
		`CHK(q, 8'h1F)
		wb(1'b1, IDX_PDT, 8'h02);
		wb(1'b1, IDX_BAL, 8'h3F);
		pin_n <= 1'b0;
		repeat (40) @(posedge clk_i);
		`CHK({pd_full, bal}, 7'h3F)
		wait_for(2'h2, 1'b1, 2 * MC + 10);
		`CHK({pd_full, bal}, 7'h40)
		pin_n <= 1'b1;
		repeat (6) @(posedge clk_i);
		$display("test power-down done");
		stop_test();
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		err_count++;
		stop_test();
	end
endmodule
`default_nettype wire
